//--- src/sas_device.sv
// Converter end of the serial link: addressing, settling, approximation and result streams.
// Assumes link pins are asynchronous to i_clk and the link clock is far slower than i_clk.
// Analog levels arrive as 8-bit samples; the comparator is modelled digitally.
module sas_device #(
  parameter int TWIN = 1                                   // 1 twin-channel, 0 single-channel
) (
  input  wire logic                              i_clk,            // System clock, 50 MHz
  input  wire logic                              i_sys_rst,        // Asynchronous reset, active high
  sas_link_if.device                             link,             // Serial link pins
  input  wire logic [sas_pkg::SAS_RES_BITS-1:0]  i_first_channel,  // First channel level
  input  wire logic [sas_pkg::SAS_RES_BITS-1:0]  i_second_channel, // Second channel level
  output logic      [sas_pkg::SAS_RES_BITS-1:0]  o_result,         // Last finished result
  output logic                                   o_result_valid    // Pulse when result finishes
);
  import sas_pkg::*;

  // Refuse variants the sequencer cannot serve
  if (TWIN != 0 && TWIN != 1) begin : g_chk_twin
    $error("TWIN must be 0 or 1");
  end

  // Two-stage synchronisers for the link pins
  logic [1:0] cs_sync_r;     // Chip select synchroniser
  logic [1:0] clk_sync_r;    // Link clock synchroniser
  logic [1:0] din_sync_r;    // Serial input synchroniser
  logic       clk_prev_r;    // Previous synchronised link clock

  // Sequencer state and datapath
  sas_dev_state_type        state_r;      // Current state
  sas_dev_state_type        state_nxt;    // Next state
  logic [2:0]               bitcnt_r;     // Bit index or assignment count
  logic [2:0]               bitcnt_nxt;
  logic [1:0]               assign_r;     // Assignment word, single-ended then parity
  logic [1:0]               assign_nxt;
  logic [7:0]               approx_r;     // Approximation register
  logic [7:0]               approx_nxt;
  logic                     dout_r;       // Serial output bit
  logic                     dout_nxt;
  logic                     oe_n_r;       // Output enable, low while driving
  logic                     oe_n_nxt;
  logic [7:0]               result_r;     // Result for the user side
  logic [7:0]               result_nxt;
  logic                     valid_r;      // Result pulse
  logic                     valid_nxt;

  // Synchronised levels and edges
  wire        cs_n_s  = cs_sync_r[1];            // Chip select after synchroniser
  wire        sclk_s  = clk_sync_r[1];           // Link clock after synchroniser
  wire        din_s   = din_sync_r[1];           // Serial input after synchroniser
  wire        rise    = sclk_s & ~clk_prev_r;    // Link clock rising edge
  wire        fall    = ~sclk_s & clk_prev_r;    // Link clock falling edge

  // Channel role decoding
  wire        sel_single = assign_r[1];          // Single-ended select bit
  wire        sel_odd    = assign_r[0];          // Parity select bit
  logic [7:0] pos_lvl;                           // Positive-assigned level
  logic [7:0] neg_lvl;                           // Negative-assigned level

  assign pos_lvl = (TWIN == 0) ? i_first_channel :
                   sel_odd     ? i_second_channel : i_first_channel;
  assign neg_lvl = (TWIN == 0)             ? i_second_channel :
                   (sel_single && !sel_odd) ? SAS_RESULT_RST :
                   sel_odd                  ? i_first_channel : i_second_channel;

  // Negative above positive clamps to zero
  wire [7:0]  diff_lvl = (pos_lvl >= neg_lvl) ? (pos_lvl - neg_lvl) : SAS_RESULT_RST;

  // Trial code for the current bit and comparator decision
  wire [7:0]  trial    = approx_r | (8'h01 << bitcnt_r);
  wire        decision = (trial <= diff_lvl);
  wire [7:0]  approx_d = decision ? trial : approx_r;

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cs_sync_r  <= 2'h3;
      clk_sync_r <= 2'h0;
      din_sync_r <= 2'h0;
      clk_prev_r <= 1'b0;
    end else begin
      cs_sync_r  <= {cs_sync_r[0], link.cs_n};
      clk_sync_r <= {clk_sync_r[0], link.sclk};
      din_sync_r <= {din_sync_r[0], link.serial_in_lvl};
      clk_prev_r <= clk_sync_r[1];
    end
  end

  // Sequencer next-state logic
  always_comb begin
    state_nxt  = state_r;
    bitcnt_nxt = bitcnt_r;
    assign_nxt = assign_r;
    approx_nxt = approx_r;
    dout_nxt   = dout_r;
    oe_n_nxt   = oe_n_r;
    result_nxt = result_r;
    valid_nxt  = 1'b0;
    // Select high clears the sequencer but keeps the result, floats output
    if (cs_n_s) begin
      state_nxt  = SAS_D_IDLE;
      bitcnt_nxt = 3'h0;
      assign_nxt = 2'h0;
      approx_nxt = SAS_RESULT_RST;
      dout_nxt   = 1'b0;
      oe_n_nxt   = 1'b1;
    end else begin
      case (state_r)
        SAS_D_IDLE: begin
          state_nxt = SAS_D_WAIT_START;
        end
        // Low bits skipped until start bit
        // Input read only while output floats
        SAS_D_WAIT_START: begin
          if (rise && din_s) begin
            state_nxt  = (TWIN != 0) ? SAS_D_ASSIGN : SAS_D_SETTLE;
            bitcnt_nxt = 3'h0;
          end
        end
        SAS_D_ASSIGN: begin
          if (rise) begin
            assign_nxt = {assign_r[0], din_s};
            // Assignment word in place, latch channel
            if (bitcnt_r == SAS_ASSIGN_LAST) begin
              state_nxt = SAS_D_SETTLE;
            end else begin
              bitcnt_nxt = bitcnt_r + 3'h1;
            end
          end
        end
        SAS_D_SETTLE: begin
          if (fall) begin
            oe_n_nxt   = 1'b0;
            dout_nxt   = 1'b0;
            bitcnt_nxt = SAS_MSB_IDX;
            state_nxt  = SAS_D_CONVERT;
          end
        end
        // Each decision shifted out as made
        SAS_D_CONVERT: begin
          if (fall) begin
            dout_nxt   = decision;
            approx_nxt = approx_d;
            if (bitcnt_r == 3'h0) begin
              result_nxt = approx_d;
              valid_nxt  = 1'b1;
              bitcnt_nxt = SAS_LSBF_FIRST;
              state_nxt  = (TWIN != 0) ? SAS_D_LSB_FIRST : SAS_D_HOLD_LOW;
            end else begin
              bitcnt_nxt = bitcnt_r - 3'h1;
            end
          end
        end
        SAS_D_LSB_FIRST: begin
          if (fall) begin
            dout_nxt = approx_r[bitcnt_r];
            if (bitcnt_r == SAS_LSBF_LAST) begin
              state_nxt = SAS_D_HOLD_LOW;
            end else begin
              bitcnt_nxt = bitcnt_r + 3'h1;
            end
          end
        end
        SAS_D_HOLD_LOW: begin
          if (fall) begin
            dout_nxt = 1'b0;
          end
        end
        // Unused codes fall back to idle
        default: begin
          state_nxt = SAS_D_IDLE;
        end
      endcase
    end
  end

  // Input path is unread outside addressing states
  // Sequencer registers
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r  <= SAS_D_IDLE;
      bitcnt_r <= 3'h0;
      assign_r <= 2'h0;
      approx_r <= SAS_RESULT_RST;
      dout_r   <= 1'b0;
      oe_n_r   <= 1'b1;
      result_r <= SAS_RESULT_RST;
      valid_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      bitcnt_r <= bitcnt_nxt;
      assign_r <= assign_nxt;
      approx_r <= approx_nxt;
      dout_r   <= dout_nxt;
      oe_n_r   <= oe_n_nxt;
      result_r <= result_nxt;
      valid_r  <= valid_nxt;
    end
  end

  // Pin and user outputs, all from flip-flops
  assign link.serial_out      = dout_r;
  assign link.serial_out_oe_n = oe_n_r;
  assign o_result             = result_r;
  assign o_result_valid       = valid_r;

endmodule

//--- src/sas_pkg.sv
// Shared constants and state types for the serial converter sequencer.
// Assumes both ends run from one 50 MHz system clock.
package sas_pkg;

  // System clock rate in hertz
  localparam int unsigned SAS_CLK_HZ     = 50_000_000;
  // Serial link clock rate in hertz
  localparam int unsigned SAS_SCLK_HZ    = 250_000;
  // System cycles per half period of the link clock
  localparam int unsigned SAS_HALF_CYC   = SAS_CLK_HZ / (2 * SAS_SCLK_HZ);

  // Result width in bits
  localparam int unsigned SAS_RES_BITS   = 8;
  // Result value after reset; approximation value after chip select release
  localparam logic [7:0]  SAS_RESULT_RST = 8'h00;

  // Index of the last assignment bit
  localparam logic [2:0]  SAS_ASSIGN_LAST = 3'h1;
  // First decision index (most significant bit)
  localparam logic [2:0]  SAS_MSB_IDX     = 3'h7;
  // First index of the reversed stream (bit 0 is not repeated)
  localparam logic [2:0]  SAS_LSBF_FIRST  = 3'h1;
  // Last index of the reversed stream
  localparam logic [2:0]  SAS_LSBF_LAST   = 3'h7;

  // Rising edges taken by addressing: start bit plus assignment word
  localparam logic [4:0]  SAS_TWIN_ADDR_RISES   = 5'h03;
  // Rising edges taken by addressing on the single variant
  localparam logic [4:0]  SAS_SINGLE_ADDR_RISES = 5'h01;
  // Settling low period in link clocks
  localparam logic [4:0]  SAS_SETTLE_RISES      = 5'h01;
  // Most-significant-first bits
  localparam logic [4:0]  SAS_MSBF_RISES        = 5'h08;
  // Least-significant-first bits on the twin variant
  localparam logic [4:0]  SAS_LSBF_RISES        = 5'h07;

  // Device sequencer states
  typedef enum logic [2:0] {
    SAS_D_IDLE       = 3'h0,
    SAS_D_WAIT_START = 3'h1,
    SAS_D_ASSIGN     = 3'h2,
    SAS_D_SETTLE     = 3'h3,
    SAS_D_CONVERT    = 3'h4,
    SAS_D_LSB_FIRST  = 3'h5,
    SAS_D_HOLD_LOW   = 3'h6
  } sas_dev_state_type;

  // Controller sequencer states
  typedef enum logic [1:0] {
    SAS_H_IDLE = 2'h0,
    SAS_H_RUN  = 2'h1,
    SAS_H_GAP  = 2'h2
  } sas_host_state_type;

endpackage

//--- src/sas_link_if.sv
// Serial link between the controller and the converter.
// Released data pins read high, as with a pull-up on the board.
interface sas_link_if;

  logic cs_n;             // Chip select, active low, from controller
  logic sclk;             // Link clock, from controller
  logic serial_in;        // Controller data toward device
  logic serial_in_oe_n;   // Low while controller drives serial_in
  logic serial_out;       // Device data toward controller
  logic serial_out_oe_n;  // Low while device drives serial_out
  logic serial_in_lvl;    // Resolved level of the input line
  logic serial_out_lvl;   // Resolved level of the output line

  // Released lines float up
  assign serial_in_lvl  = serial_in_oe_n ? 1'b1 : serial_in;
  assign serial_out_lvl = serial_out_oe_n ? 1'b1 : serial_out;

  // Converter end
  modport device (
    input  cs_n, sclk, serial_in_lvl,
    output serial_out, serial_out_oe_n
  );

  // Controller end
  modport host (
    input  serial_out_lvl,
    output cs_n, sclk, serial_in, serial_in_oe_n
  );

endinterface

//--- src/sas_host.sv
// Controller end of the serial link: makes the link clock, sends address, collects result.
// Assumes the converter follows the documented sequence; runs on one system clock.
module sas_host #(
  parameter int TWIN     = 1,                        // 1 twin-channel device, 0 single
  parameter int HALF_CYC = sas_pkg::SAS_HALF_CYC     // System cycles per link half period
) (
  input  wire logic                              i_clk,           // System clock, 50 MHz
  input  wire logic                              i_sys_rst,       // Asynchronous reset, active high
  sas_link_if.host                               link,            // Serial link pins
  input  wire logic                              i_start,         // Pulse: start a conversion
  input  wire logic                              i_single_ended,  // Assignment single-ended bit
  input  wire logic                              i_odd_select,    // Assignment parity bit
  output logic                                   o_busy,          // Conversion in progress
  output logic      [sas_pkg::SAS_RES_BITS-1:0]  o_result,        // Most-significant-first result
  output logic                                   o_result_valid,  // Pulse when result ready
  output logic                                   o_lsb_agree      // Reversed stream matched
);
  import sas_pkg::*;

  // Refuse settings the logic cannot serve
  if (TWIN != 0 && TWIN != 1) begin : g_chk_twin
    $error("TWIN must be 0 or 1");
  end
  if (HALF_CYC < 8 || HALF_CYC > 65535) begin : g_chk_half
    $error("HALF_CYC must be 8 to 65535");
  end

  // Edge counts of one conversion
  localparam logic [4:0]  ADDR_RISES = (TWIN != 0) ? SAS_TWIN_ADDR_RISES : SAS_SINGLE_ADDR_RISES;
  localparam logic [4:0]  MSB_FIRST  = ADDR_RISES + SAS_SETTLE_RISES + 5'h01;
  localparam logic [4:0]  MSB_LAST   = ADDR_RISES + SAS_SETTLE_RISES + SAS_MSBF_RISES;
  localparam logic [4:0]  TOTAL      = MSB_LAST + ((TWIN != 0) ? SAS_LSBF_RISES : 5'h00);
  localparam logic [15:0] HALF_LAST  = 16'(HALF_CYC - 1);

  sas_host_state_type state_r;     // Current state
  logic [15:0]        div_r;       // Half-period divider
  logic               sclk_r;      // Link clock output
  logic               cs_n_r;      // Chip select output
  logic               din_r;       // Serial data output
  logic               din_oe_n_r;  // Low while driving serial data
  logic [4:0]         rises_r;     // Rising edges issued
  logic [1:0]         mode_r;      // Latched assignment word
  logic [7:0]         msb_r;       // Most-significant-first bits
  logic [6:0]         lsb_r;       // Reversed bits 1 to 7
  logic [7:0]         result_r;    // Result output
  logic               valid_r;     // Result pulse
  logic               agree_r;     // Reversed stream match flag
  logic [1:0]         dout_sync_r; // Serial output synchroniser

  // Divider tick and edge decode
  wire tick     = (state_r != SAS_H_IDLE) && (div_r == HALF_LAST);
  wire rise_now = tick && (state_r == SAS_H_RUN) && !sclk_r;
  wire fall_now = tick && (state_r == SAS_H_RUN) && sclk_r;
  wire dout_s   = dout_sync_r[1];
  wire [4:0] rise_num = rises_r + 5'h01;         // Number of the edge being issued

  // Device data synchroniser
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dout_sync_r <= 2'h3;
    end else begin
      dout_sync_r <= {dout_sync_r[0], link.serial_out_lvl};
    end
  end

  // Divider
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= (tick || state_r == SAS_H_IDLE) ? 16'h0000 : div_r + 16'h0001;
    end
  end

  // Sequencer: start bit set up before the first rising edge
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r    <= SAS_H_IDLE;
      sclk_r     <= 1'b0;
      cs_n_r     <= 1'b1;
      din_r      <= 1'b0;
      din_oe_n_r <= 1'b1;
      rises_r    <= 5'h00;
      mode_r     <= 2'h0;
      msb_r      <= 8'h00;
      lsb_r      <= 7'h00;
      result_r   <= 8'h00;
      valid_r    <= 1'b0;
      agree_r    <= 1'b0;
    end else begin
      valid_r <= 1'b0;
      case (state_r)
        // Wait for a request, then select and present start bit
        SAS_H_IDLE: begin
          if (i_start) begin
            state_r    <= SAS_H_RUN;
            cs_n_r     <= 1'b0;
            din_r      <= 1'b1;
            din_oe_n_r <= 1'b0;
            rises_r    <= 5'h00;
            mode_r     <= {i_single_ended, i_odd_select};
          end
        end
        // Clock the link; sample on rising, update on falling
        SAS_H_RUN: begin
          if (rise_now) begin
            sclk_r  <= 1'b1;
            rises_r <= rise_num;
            if (rise_num >= MSB_FIRST && rise_num <= MSB_LAST) begin
              msb_r <= {msb_r[6:0], dout_s};
            end else if (rise_num > MSB_LAST) begin
              lsb_r <= {dout_s, lsb_r[6:1]};
            end
          end else if (fall_now) begin
            sclk_r <= 1'b0;
            // Release data once addressing ends, else next bit
            // Assignment word bits
            if (rises_r == ADDR_RISES) begin
              din_oe_n_r <= 1'b1;
              din_r      <= 1'b0;
            end else if (rises_r == 5'h01) begin
              din_r <= mode_r[1];
            end else if (rises_r == 5'h02) begin
              din_r <= mode_r[0];
            end
            // Last edge done: release select
            // Select held whole frame
            if (rises_r == TOTAL) begin
              cs_n_r  <= 1'b1;
              state_r <= SAS_H_GAP;
            end
          end
        end
        // Select high for one half period before the next request
        // Select toggles between frames
        SAS_H_GAP: begin
          if (tick) begin
            state_r  <= SAS_H_IDLE;
            result_r <= msb_r;
            valid_r  <= 1'b1;
            agree_r  <= (TWIN == 0) || (lsb_r == msb_r[7:1]);
          end
        end
        default: begin
          state_r <= SAS_H_IDLE;
        end
      endcase
    end
  end

  // Pin and user outputs
  assign link.sclk           = sclk_r;
  assign link.cs_n           = cs_n_r;
  assign link.serial_in      = din_r;
  assign link.serial_in_oe_n = din_oe_n_r;
  assign o_busy              = (state_r != SAS_H_IDLE);
  assign o_result            = result_r;
  assign o_result_valid      = valid_r;
  assign o_lsb_agree         = agree_r;

endmodule

//--- dv/sas_link_assertions.sv
// Concurrent checks on the serial link between the controller and converter ends.
// Assumes the interface signals are fed in directly and one system clock drives both ends.
module sas_link_assertions #(
  parameter int TWIN = 1                 // 1 twin-channel, 0 single-channel
) (
  input  wire logic  i_clk,              // System clock
  input  wire logic  i_sys_rst,          // Asynchronous reset, active high
  input  wire logic  cs_n,               // Chip select, active low
  input  wire logic  sclk,               // Link clock
  input  wire logic  serial_in_oe_n,     // Low while controller drives
  input  wire logic  serial_out,         // Converter data
  input  wire logic  serial_out_oe_n     // Low while converter drives
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] ADDR_RISE = (TWIN != 0) ? 5'h03 : 5'h01;  // Rises taken by addressing
  localparam logic [4:0] LAST_RISE = (TWIN != 0) ? 5'h13 : 5'h0A;  // Rises in a whole frame
  logic        sclk_r;                                        // Link clock one cycle ago
  logic  [4:0] rises_r;                                       // Link rises in this frame
  logic  [3:0] fall_age_r;                                    // Cycles since last link fall
  wire         rise_w     = sclk & ~sclk_r;                   // Link rising edge
  wire         fall_w     = ~sclk & sclk_r;                   // Link falling edge
  wire   [4:0] rises_nxt  = cs_n ? 5'h00 : rises_r + {4'h0, rise_w};
  wire   [3:0] fall_age_nxt = fall_w ? 4'h0 : ((fall_age_r == 4'hF) ? 4'hF : fall_age_r + 4'h1);

  // Link edge history and frame counters
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_r     <= 1'b0;
      rises_r    <= 5'h00;
      fall_age_r <= 4'hF;
    end else begin
      sclk_r     <= sclk;
      rises_r    <= rises_nxt;
      fall_age_r <= fall_age_nxt;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  // Converter takes the line, starting with a low
  sequence s_take_line;
    $fell(serial_out_oe_n);
  endsequence
  sequence s_frame_end;
    $rose(cs_n);
  endsequence

  chk_settle_low: assert property (s_take_line |-> !serial_out)
    else $error("converter did not open with a low");
  chk_addr_count: assert property (s_take_line |-> rises_r == ADDR_RISE)
    else $error("converter drove before addressing ended");
  chk_frame_length: assert property (s_frame_end |-> rises_r == LAST_RISE)
    else $error("frame rise count wrong");
  chk_idle_float: assert property (cs_n [*5] |-> serial_out_oe_n)
    else $error("output still driven after deselect");
  chk_hold_drive: assert property (!cs_n && !serial_out_oe_n |=> !serial_out_oe_n)
    else $error("output released while selected");
  chk_no_contend: assert property (!serial_out_oe_n |-> serial_in_oe_n)
    else $error("both ends drive the link");
  chk_fall_update: assert property ($changed(serial_out) && !serial_out_oe_n && !$past(serial_out_oe_n)
    |-> fall_age_r <= 4'h6)
    else $error("output changed away from a falling edge");
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("link clock runs while deselected");
endmodule

//--- dv/tb_serial_adc_sequencer.sv
// Self-checking bench: controller and converter joined by one link, a second converter bit-banged.
// Assumes the sequencer package and link interface are compiled first.
module tb_serial_adc_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import sas_pkg::*;
  localparam int HALF = 8;                    // Short link half period
  logic        i_clk, i_sys_rst, i_start;     // Clock, reset, start pulse
  logic        i_single_ended, i_odd_select;  // Assignment word
  logic  [7:0] first_r, second_r;             // Channel stand-ins
  logic        h_busy, h_valid, h_agree;      // Controller status
  logic        d_valid, d2_valid, sclk_q;     // Converter pulses, clock history
  logic  [7:0] h_result, d_result, d2_result; // Results
  logic [18:0] wire_bits;                     // Data line seen at link rises
  logic [11:0] bits_b;                        // Second link capture
  logic [31:0] rnd;                           // Random word
  int          mismatches, num_checks, seed;  // Counters and seed
  int          cycles = 0;                    // Timeout counter
  int          pulses = 0, p0;                // Converter result pulses, count at frame start
  logic  [7:0] s_result, s_dres;              // Single-channel pair results
  sas_link_if link();                         // Joins both design ends
  sas_link_if link_c();                       // Joins the single-channel pair
  sas_link_if link_b();                       // Driven by the bench

  sas_host #(.TWIN(1), .HALF_CYC(HALF)) i_sas_host (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(link),
    .i_start(i_start), .i_single_ended(i_single_ended), .i_odd_select(i_odd_select), .o_busy(h_busy),
    .o_result(h_result), .o_result_valid(h_valid), .o_lsb_agree(h_agree));
  sas_device #(.TWIN(1)) i_sas_device (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(link),
    .i_first_channel(first_r), .i_second_channel(second_r), .o_result(d_result), .o_result_valid(d_valid));
  sas_device #(.TWIN(1)) i_sas_device_2 (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(link_b),
    .i_first_channel(first_r), .i_second_channel(second_r), .o_result(d2_result), .o_result_valid(d2_valid));
  sas_link_assertions #(.TWIN(1)) i_sas_link_assertions (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .cs_n(link.cs_n), .sclk(link.sclk), .serial_in_oe_n(link.serial_in_oe_n),
    .serial_out(link.serial_out), .serial_out_oe_n(link.serial_out_oe_n));
  sas_host #(.TWIN(0), .HALF_CYC(HALF)) i_sas_host_1 (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(link_c),
    .i_start(i_start), .i_single_ended(1'b0), .i_odd_select(1'b0), .o_busy(), .o_result(s_result),
    .o_result_valid(), .o_lsb_agree());
  sas_device #(.TWIN(0)) i_sas_device_1 (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .link(link_c),
    .i_first_channel(first_r), .i_second_channel(second_r), .o_result(s_dres), .o_result_valid());

  // Clock source
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Data line capture on link rises, and hang guard
  always @(posedge i_clk) begin
    sclk_q <= link.sclk;
    if (link.sclk && !sclk_q) wire_bits <= {wire_bits[17:0], link.serial_out_lvl};
    cycles <= cycles + 1;
    pulses <= pulses + d_valid + d2_valid;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      give_verdict();
    end
  end

  // Expected code from assignment roles
  function automatic logic [7:0] exp_res(input logic se, input logic odd, input logic [7:0] a, b);
    logic [7:0] p, n;
    p = odd ? b : a;
    n = odd ? a : (se ? 8'h00 : b);
    exp_res = (p > n) ? p - n : 8'h00;
  endfunction

  // Expected line: released start/word, settle low, MSB first, then bits 1..7
  function automatic logic [18:0] exp_wire(input logic [7:0] r);
    exp_wire = {4'hE, r, r[1], r[2], r[3], r[4], r[5], r[6], r[7]};
  endfunction

  task automatic check(input string what, input logic [18:0] seen, input logic [18:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One conversion through the controller, with a stray start mid-frame
  task automatic convert(input logic se, input logic odd, input logic [7:0] a, b);
    logic [7:0] r;
    int n;
    r = exp_res(se, odd, a, b);
    p0 = pulses;
    n = 0;
    first_r <= a;
    second_r <= b;
    i_single_ended <= se;
    i_odd_select <= odd;
    i_start <= 1'b1;
    @(posedge i_clk) i_start <= 1'b0;
    repeat (40) @(posedge i_clk);
    i_single_ended <= ~se;
    i_start <= 1'b1;
    @(posedge i_clk) i_start <= 1'b0;
    do begin
      @(negedge i_clk);
      n++;
    end while (h_valid !== 1'b1 && n < 1000);
    check("host valid seen", h_valid, 1'b1);
    check("host result", h_result, r);
    check("device result", d_result, r);
    check("device pulse", 19'(pulses - p0), 19'h00001);
    check("lsb agree", h_agree, 1'b1);
    check("line stream", wire_bits, exp_wire(r));
    check("single host result", s_result, exp_res(1'b0, 1'b0, a, b));
    check("single device result", s_dres, exp_res(1'b0, 1'b0, a, b));
    repeat (2 * HALF) @(negedge i_clk);
    check("busy after stray start", h_busy, 1'b0);
    check("idle line", link.serial_out_lvl, 1'b1);
    @(posedge i_clk);
  endtask

  // One link clock period on the second link, sampled before the fall
  task automatic lb_bit(input logic d);
    link_b.serial_in <= d;
    link_b.sclk <= 1'b0;
    repeat (HALF) @(posedge i_clk);
    link_b.sclk <= 1'b1;
    repeat (HALF) @(posedge i_clk);
    bits_b = {bits_b[10:0], link_b.serial_out_lvl};
  endtask

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    seed = 32'h4FF3;
    mismatches = 0;
    num_checks = 0;
    i_sys_rst = 1'b1;
    i_start = 1'b0;
    i_single_ended = 1'b0;
    i_odd_select = 1'b0;
    first_r = 8'h00;
    second_r = 8'h00;
    link_b.cs_n = 1'b1;
    link_b.sclk = 1'b0;
    link_b.serial_in = 1'b0;
    link_b.serial_in_oe_n = 1'b1;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    // Every assignment code, then range corners
    for (int k = 0; k < 4; k++) convert(k[1], k[0], 8'hC8, 8'h37);
    convert(1'b0, 1'b0, 8'h10, 8'h20);
    convert(1'b1, 1'b0, 8'hFF, 8'h00);
    convert(1'b0, 1'b1, 8'h00, 8'hFF);
    for (int k = 0; k < 12; k++) begin
      rnd = $random(seed);
      convert(rnd[0], rnd[1], rnd[15:8], rnd[23:16]);
    end
    // Reset in mid-frame clears the link
    i_start <= 1'b1;
    @(posedge i_clk) i_start <= 1'b0;
    repeat (100) @(posedge i_clk);
    i_sys_rst <= 1'b1;
    @(negedge i_clk);
    check("cs after reset", link.cs_n, 1'b1);
    check("line after reset", link.serial_out_lvl, 1'b1);
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    convert(1'b1, 1'b1, 8'h5A, 8'hA5);
    // Lows before start, noisy input during conversion, abort after the first reversed bit
    rnd = $random(seed);
    p0 = pulses;
    first_r <= rnd[7:0];
    link_b.cs_n <= 1'b0;
    link_b.serial_in_oe_n <= 1'b0;
    repeat (3) lb_bit(1'b0);
    lb_bit(1'b1);
    lb_bit(1'b1);
    lb_bit(1'b0);
    for (int k = 0; k < 9; k++) lb_bit(rnd[k + 8]);
    link_b.sclk <= 1'b0;
    repeat (HALF) @(posedge i_clk);
    link_b.cs_n <= 1'b1;
    repeat (6) @(negedge i_clk);
    check("ignored lows", bits_b[8:0], {1'b0, first_r});
    check("ignored input", d2_result, first_r);
    check("second pulse", 19'(pulses - p0), 19'h00001);
    check("aborted line", link_b.serial_out_lvl, 1'b1);
    give_verdict();
  end
endmodule
